// ==== design/diag_frame_pkg.sv ====
// Constants for the diagnostic status frame scheduler.
// Assumes a 200 MHz ref_clk and a CAN controller that takes one whole frame per handshake.
package diag_frame_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned CLK_NS = 5;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
  localparam int unsigned FAST_PERIOD_MS = 100;
  localparam int unsigned SLOW_PERIOD_MS = 1000;
  localparam int unsigned IDLE_PERIOD_MS = 5000;
  localparam int unsigned CLEAR_DEADLINE_MS = 1000;
  localparam int unsigned MANUAL_TIMEOUT_MS = 500;
  // ---------------------------------------------------------------
  // Frame identity
  // ---------------------------------------------------------------
  localparam logic [17:0] DIAG_GROUP = 18'h1feca;
  localparam logic [17:0] REQUEST_GROUP = 18'h0ea00;
  localparam logic [2:0] DIAG_PRIORITY = 3'h6;
  localparam logic [2:0] CONTROL_PRIORITY = 3'h3;
  localparam logic [2:0] INFO_PRIORITY = 3'h6;
  // ---------------------------------------------------------------
  // Payload fill values
  // ---------------------------------------------------------------
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [6:0] COUNT_UNAVAIL = 7'h7f;
  localparam logic [3:0] BANK_NONE = 4'hf;
  localparam logic [3:0] BANK_MAX = 4'hd;
  localparam logic [1:0] ST_OFF = 2'h0;
  localparam logic [1:0] ST_ON = 2'h1;
  localparam logic [1:0] RUN_STANDBY = 2'h0;
  localparam logic [1:0] RUN_ACTIVE = 2'h1;
  localparam logic [1:0] LAMP_OFF = 2'h0;
  localparam logic [1:0] LAMP_ON = 2'h1;
  // ---------------------------------------------------------------
  // Frame kinds offered to the CAN controller
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_DIAG = 2'b01,
    KIND_STATUS = 2'b10
  } frame_kind_type;
endpackage : diag_frame_pkg

// ==== design/diag_status_frame_scheduler.sv ====
// Diagnostic status frame scheduler: builds the single-frame diagnostic
// message and decides when it, or the device status group, goes out.
// Assumes the CAN controller takes a frame on tx_valid and tx_ready high.
`timescale 1ns/1ps
module diag_status_frame_scheduler
  import diag_frame_pkg::*;
#(
  parameter int unsigned MS_DIV = diag_frame_pkg::MS_CYCLES,
  parameter int unsigned MANUAL_TIMEOUT = diag_frame_pkg::MANUAL_TIMEOUT_MS
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Device state
  input wire logic automated,
  input wire logic dev_enabled,
  input wire logic dev_running,
  input wire logic fault_active,
  input wire logic fault_severe,
  input wire logic warn_lamp,
  input wire logic severe_lamp,
  input wire logic [7:0] default_source_address,
  input wire logic [18:0] failed_component_number,
  input wire logic [4:0] failure_mode_code,
  input wire logic count_valid,
  input wire logic [6:0] occurrence_count,
  input wire logic ext_valid,
  input wire logic [7:0] address_extension,
  input wire logic bank_valid,
  input wire logic [3:0] bank_select,
  // Received traffic, one-cycle pulses
  input wire logic rx_valid,
  input wire logic [17:0] rx_group,
  input wire logic [23:0] rx_req_group,
  input wire logic ctrl_cmd,
  input wire logic ctrl_manual,
  input wire logic ctrl_stop,
  input wire logic motion_done,
  input wire logic status_sent,
  // Frame to CAN controller
  output frame_kind_type tx_kind,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [17:0] tx_group,
  output logic [2:0] tx_priority,
  output logic [63:0] tx_data,
  // Safety
  output logic manual_safe_stop,
  output logic manual_active
);
  import diag_frame_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] div;
    logic ms_tick;
    logic [12:0] idle_ms;
    logic [12:0] fault_ms;
    logic [12:0] clear_ms;
    logic [12:0] manual_ms;
    logic diag_pend;
    logic status_pend;
    logic clear_pend;
    logic reported;
    logic manual;
    logic safe_stop;
    logic busy;
    logic data_fault;
    frame_kind_type kind;
    logic [63:0] data;
  } state_type;

  state_type cur_ff;
  state_type nxt_cur;

  localparam logic [12:0] FAST_LIM = 13'(FAST_PERIOD_MS);
  localparam logic [12:0] SLOW_LIM = 13'(SLOW_PERIOD_MS);
  localparam logic [12:0] IDLE_LIM = 13'(IDLE_PERIOD_MS);
  localparam logic [12:0] CLR_LIM = 13'(CLEAR_DEADLINE_MS);
  // Clear deadline leaves margin so a stalled bus still meets it
  localparam logic [12:0] CLR_SEND = 13'(CLEAR_DEADLINE_MS / 2);
  localparam logic [12:0] MAN_LIM = 13'(MANUAL_TIMEOUT);
  localparam logic [31:0] DIV_LAST = 32'(MS_DIV - 1);

  logic is_request;
  logic diag_due;
  logic [7:0] byte0;
  logic [31:0] fault_bytes;
  logic [7:0] byte5;
  logic [63:0] diag_payload;

  // ---------------------------------------------------------------
  // Payload assembly
  // ---------------------------------------------------------------
  always_comb
  begin
    // Encoding is the same for simple and automated devices; the flag
    // only documents which meaning standby carries
    byte0 = {severe_lamp ? LAMP_ON : LAMP_OFF,
             warn_lamp ? LAMP_ON : LAMP_OFF,
             dev_running ? RUN_ACTIVE : RUN_STANDBY,
             dev_enabled ? ST_ON : ST_OFF};
    // Bytes two to five, byte two in the low lane; bit 7 of byte five is fixed
    byte5 = {1'b1, count_valid ? occurrence_count : COUNT_UNAVAIL};
    fault_bytes = {byte5, failed_component_number[2:0], failure_mode_code,
                   failed_component_number[10:3], failed_component_number[18:11]};
    // Nothing to report: the fault fields read as not available
    if (!fault_active)
      fault_bytes = {ALL_ONES, ALL_ONES, ALL_ONES, ALL_ONES};
    // Byte 0 sits in the low lane of tx_data; the upper bank nibble is unused
    diag_payload = {ALL_ONES[7:4],
                    (bank_valid && bank_select <= BANK_MAX) ? bank_select : BANK_NONE,
                    ext_valid ? address_extension : ALL_ONES,
                    fault_bytes, default_source_address, byte0};
  end

  assign is_request = rx_valid && rx_group[17:8] == REQUEST_GROUP[17:8]
                      && rx_req_group[17:0] == DIAG_GROUP;

  // ---------------------------------------------------------------
  // Scheduling
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_cur = cur_ff;
    diag_due = 1'b0;
    // Millisecond strobe from the divider
    nxt_cur.ms_tick = 1'b0;
    if (cur_ff.div == DIV_LAST)
    begin
      nxt_cur.div = '0;
      nxt_cur.ms_tick = 1'b1;
    end
    else
    begin
      nxt_cur.div = cur_ff.div + 32'h1;
    end
    if (cur_ff.ms_tick)
    begin
      if (cur_ff.idle_ms < IDLE_LIM)
        nxt_cur.idle_ms = cur_ff.idle_ms + 13'h1;
      if (cur_ff.fault_ms < IDLE_LIM)
        nxt_cur.fault_ms = cur_ff.fault_ms + 13'h1;
      if (cur_ff.clear_pend && cur_ff.clear_ms < CLR_LIM)
        nxt_cur.clear_ms = cur_ff.clear_ms + 13'h1;
      if (cur_ff.manual && cur_ff.manual_ms < MAN_LIM)
        nxt_cur.manual_ms = cur_ff.manual_ms + 13'h1;
    end
    // Fault repetition: 100 ms for severe faults, 1000 ms otherwise
    if (fault_active)
    begin
      nxt_cur.reported = cur_ff.reported;
      if (cur_ff.fault_ms >= (fault_severe ? FAST_LIM : SLOW_LIM))
        diag_due = 1'b1;
    end
    else if (cur_ff.reported)
    begin
      nxt_cur.clear_pend = 1'b1;
      nxt_cur.reported = 1'b0;
      nxt_cur.clear_ms = '0;
    end
    if (cur_ff.clear_pend && cur_ff.clear_ms >= CLR_SEND)
      diag_due = 1'b1;
    if (cur_ff.idle_ms >= IDLE_LIM)
      diag_due = 1'b1;
    if (is_request)
      diag_due = 1'b1;
    // A due timer keeps asking until its frame is gone; while that frame is
    // offered only a fresh request may queue another, or it would go out twice
    if (cur_ff.busy && cur_ff.kind == KIND_DIAG)
      diag_due = is_request;
    if (diag_due)
      nxt_cur.diag_pend = 1'b1;
    // Control commands and motion completion demand status feedback
    if (rx_valid && (ctrl_cmd || motion_done))
      nxt_cur.status_pend = 1'b1;
    // Manual mode watchdog
    if (rx_valid && ctrl_cmd && ctrl_manual && !ctrl_stop)
    begin
      nxt_cur.manual = 1'b1;
      nxt_cur.manual_ms = '0;
      nxt_cur.safe_stop = 1'b0;
    end
    else if (rx_valid && ctrl_cmd && ctrl_stop)
    begin
      nxt_cur.manual = 1'b0;
    end
    else if (cur_ff.manual && cur_ff.manual_ms >= MAN_LIM)
    begin
      nxt_cur.manual = 1'b0;
      nxt_cur.safe_stop = 1'b1;
    end
    // Issue a frame; status feedback first since it answers a command
    if (!cur_ff.busy)
    begin
      if (cur_ff.status_pend)
      begin
        nxt_cur.busy = 1'b1;
        nxt_cur.kind = KIND_STATUS;
        nxt_cur.status_pend = 1'b0;
        nxt_cur.data = '0;
      end
      else if (cur_ff.diag_pend)
      begin
        nxt_cur.busy = 1'b1;
        nxt_cur.kind = KIND_DIAG;
        // Timers stay due until the handshake restarts them; keep only requests
        nxt_cur.diag_pend = is_request;
        nxt_cur.data_fault = fault_active;
        nxt_cur.data = diag_payload;
      end
    end
    else if (tx_ready)
    begin
      nxt_cur.busy = 1'b0;
      nxt_cur.kind = KIND_NONE;
      nxt_cur.idle_ms = '0;
      if (cur_ff.kind == KIND_DIAG)
      begin
        nxt_cur.fault_ms = '0;
        // Judge by what the frame carried: a fault that clears while its
        // frame waits for the bus still owes a clear report
        nxt_cur.reported = cur_ff.data_fault;
        if (cur_ff.data_fault == fault_active)
          nxt_cur.clear_pend = 1'b0;
      end
    end
    // Status frames sent elsewhere also count as traffic
    if (status_sent)
      nxt_cur.idle_ms = '0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      cur_ff <= '{kind: KIND_NONE, default: '0};
    else
      cur_ff <= nxt_cur;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign tx_valid = cur_ff.busy;
  assign tx_kind = cur_ff.kind;
  assign tx_data = cur_ff.data;
  assign tx_group = (cur_ff.kind == KIND_DIAG) ? DIAG_GROUP : '0;
  assign tx_priority = (cur_ff.kind == KIND_STATUS) ? CONTROL_PRIORITY
                       : DIAG_PRIORITY;
  assign manual_safe_stop = cur_ff.safe_stop;
  assign manual_active = cur_ff.manual;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_bit7;
    @(posedge ref_clk) disable iff (reset)
      tx_valid && tx_kind == KIND_DIAG |-> tx_data[47];
  endproperty
  a_bit7: assert property (p_bit7) else $error("byte five bit 7 clear");

  property p_nofault_fill;
    @(posedge ref_clk) disable iff (reset)
      !cur_ff.busy && !cur_ff.status_pend && cur_ff.diag_pend && !fault_active
      |=> tx_data[47:16] == 32'hffffffff;
  endproperty
  a_nofault_fill: assert property (p_nofault_fill) else $error("idle fill wrong");

  property p_group;
    @(posedge ref_clk) disable iff (reset)
      tx_kind == KIND_DIAG |-> tx_group == DIAG_GROUP && tx_priority == DIAG_PRIORITY;
  endproperty
  a_group: assert property (p_group) else $error("diag group wrong");

  property p_request;
    @(posedge ref_clk) disable iff (reset)
      is_request |=> cur_ff.diag_pend || (tx_kind == KIND_DIAG);
  endproperty
  a_request: assert property (p_request) else $error("request not queued");

  // Overdue silence must queue a frame or already be sending one
  property p_idle_bound;
    @(posedge ref_clk) disable iff (reset)
      cur_ff.idle_ms >= IDLE_LIM && !(tx_valid && tx_ready)
      |=> cur_ff.diag_pend || cur_ff.busy;
  endproperty
  a_idle_bound: assert property (p_idle_bound) else $error("idle timer overrun");

  property p_cmd_feedback;
    @(posedge ref_clk) disable iff (reset)
      rx_valid && ctrl_cmd |=> cur_ff.status_pend || tx_kind == KIND_STATUS;
  endproperty
  a_cmd_feedback: assert property (p_cmd_feedback) else $error("no feedback");

  property p_sent_resets;
    @(posedge ref_clk) disable iff (reset)
      tx_valid && tx_ready |=> cur_ff.idle_ms == '0;
  endproperty
  a_sent_resets: assert property (p_sent_resets) else $error("idle not restarted");

  property p_tick;
    @(posedge ref_clk) disable iff (reset)
      cur_ff.ms_tick |=> !cur_ff.ms_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too long");

  property p_safe;
    @(posedge ref_clk) disable iff (reset)
      cur_ff.manual && cur_ff.manual_ms >= MAN_LIM && !(rx_valid && ctrl_cmd)
      |=> manual_safe_stop && !manual_active;
  endproperty
  a_safe: assert property (p_safe) else $error("no safe stop");

  property p_bank;
    @(posedge ref_clk) disable iff (reset)
      tx_kind == KIND_DIAG |-> tx_data[59:56] <= BANK_MAX || tx_data[59:56] == BANK_NONE;
  endproperty
  a_bank: assert property (p_bank) else $error("bank out of range");

  // One frame per due timer: no diag frame queued straight after a diag frame
  property p_single_repeat;
    @(posedge ref_clk) disable iff (reset)
      tx_valid && tx_ready && tx_kind == KIND_DIAG && !cur_ff.diag_pend && !is_request
      |=> !cur_ff.diag_pend;
  endproperty
  a_single_repeat: assert property (p_single_repeat) else $error("diag frame doubled");

  // A due clear report, or status feedback queued ahead of it, is offered within two cycles when the bus is free
  property p_clear_report;
    @(posedge ref_clk) disable iff (reset)
      cur_ff.clear_pend && cur_ff.clear_ms >= CLR_SEND && !cur_ff.busy
      |-> ##[1:2] tx_valid;
  endproperty
  a_clear_report: assert property (p_clear_report) else $error("clear report late");

  // Without a fault, a request, a clear or overdue silence no diag frame is queued
  property p_quiet;
    @(posedge ref_clk) disable iff (reset)
      !fault_active && !cur_ff.clear_pend && cur_ff.idle_ms < IDLE_LIM && !is_request
      && !cur_ff.diag_pend |=> !cur_ff.diag_pend;
  endproperty
  a_quiet: assert property (p_quiet) else $error("unrequested diag frame");

  c_diag: cover property (@(posedge ref_clk) tx_valid && tx_ready && tx_kind == KIND_DIAG);
  c_status: cover property (@(posedge ref_clk) tx_valid && tx_ready && tx_kind == KIND_STATUS);
  c_clear: cover property (@(posedge ref_clk) cur_ff.clear_pend);
  c_safe: cover property (@(posedge ref_clk) manual_safe_stop);
endmodule : diag_status_frame_scheduler

// ==== dv/can_ctrl_model.sv ====
// Partner model: the CAN controller that takes frames from the scheduler.
// Assumes the scheduler's clock and reset; the bench reads its counters.
`timescale 1ns/1ps
module can_ctrl_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Frame offer from the scheduler
  input wire diag_frame_pkg::frame_kind_type tx_kind,
  input wire logic tx_valid,
  input wire logic [17:0] tx_group,
  input wire logic [2:0] tx_priority,
  input wire logic [63:0] tx_data,
  output logic tx_ready,
  // Bench control and observation
  input wire logic slow,
  output int n_diag,
  output int n_status,
  output logic [63:0] last_data,
  output logic [17:0] last_group,
  output logic [2:0] last_prio,
  output int last_cycle
);
  import diag_frame_pkg::*;
  int cyc_ff;
  int wait_ff;

  // Ready is registered and low between frames; slow mode stalls each
  // frame as a controller losing arbitration would
  always_ff @(posedge ref_clk)
  begin
    cyc_ff <= cyc_ff + 1;
    if (reset)
    begin
      tx_ready <= 1'b0;
      wait_ff <= 0;
      n_diag <= 0;
      n_status <= 0;
      last_cycle <= 0;
    end
    else if (tx_valid && tx_ready)
    begin
      tx_ready <= 1'b0;
      wait_ff <= 0;
      last_data <= tx_data;
      last_group <= tx_group;
      last_prio <= tx_priority;
      last_cycle <= cyc_ff;
      if (tx_kind == KIND_DIAG) n_diag <= n_diag + 1;
      if (tx_kind == KIND_STATUS) n_status <= n_status + 1;
    end
    else if (tx_valid)
    begin
      wait_ff <= wait_ff + 1;
      tx_ready <= (wait_ff >= (slow ? 3 : 0));
    end
  end
endmodule : can_ctrl_model

// ==== dv/diag_status_frame_scheduler_tb_top.sv ====
// Self-checking bench for the diagnostic status frame scheduler.
// Assumes a shortened millisecond divider so the idle timer fits the run.
`timescale 1ns/1ps
module diag_status_frame_scheduler_tb_top;
  import diag_frame_pkg::*;
  localparam int MSD = 4;
  localparam int MTO = 5;
  logic ref_clk = 0, reset = 1, automated = 0, dev_enabled = 0, dev_running = 0;
  logic fault_active = 0, fault_severe = 0, warn_lamp = 0, severe_lamp = 0;
  logic count_valid = 0, ext_valid = 0, bank_valid = 0, rx_valid = 0, ctrl_cmd = 0;
  logic ctrl_manual = 0, ctrl_stop = 0, motion_done = 0, status_sent = 0, slow = 0;
  logic [3:0] bank_select = 4'h0;
  logic [17:0] rx_group = 18'h0;
  logic [23:0] rx_req_group = 24'h0;
  logic [7:0] default_source_address = 8'h42, address_extension = 8'h12;
  logic [18:0] failed_component_number = 19'h02078;
  logic [4:0] failure_mode_code = 5'h07;
  logic [6:0] occurrence_count = 7'h05;
  frame_kind_type tx_kind;
  logic tx_valid, tx_ready, manual_safe_stop, manual_active;
  logic [17:0] tx_group, last_group;
  logic [2:0] tx_priority, last_prio;
  logic [63:0] tx_data, last_data;
  int n_diag, n_status, last_cycle, mismatches = 0, n_checks = 0, n0, t1;
  // Rows: {automated, fault, enable, run, warn, severe, count/ext/bank valid, bank}
  logic [12:0] in_tab [5] = '{13'h0673, 13'h0d5d, 13'h0abe, 13'h1400, 13'h0000};
  logic [63:0] exp_tab [5] = '{64'hf312ffffffff4205, 64'hfdff85070f044211,
    64'hff12ff070f044244, 64'hffffffffffff4201, 64'hffffffffffff4200};

  diag_status_frame_scheduler #(.MS_DIV(MSD), .MANUAL_TIMEOUT(MTO)) i_dut (.ref_clk, .reset,
    .automated, .dev_enabled, .dev_running, .fault_active, .fault_severe, .warn_lamp,
    .severe_lamp, .default_source_address, .failed_component_number, .failure_mode_code,
    .count_valid, .occurrence_count, .ext_valid, .address_extension, .bank_valid,
    .bank_select, .rx_valid, .rx_group, .rx_req_group, .ctrl_cmd, .ctrl_manual, .ctrl_stop,
    .motion_done, .status_sent, .tx_kind, .tx_valid, .tx_ready, .tx_group, .tx_priority,
    .tx_data, .manual_safe_stop, .manual_active);
  can_ctrl_model i_can (.ref_clk, .reset, .tx_kind, .tx_valid, .tx_group, .tx_priority,
    .tx_data, .tx_ready, .slow, .n_diag, .n_status, .last_data, .last_group, .last_prio,
    .last_cycle);

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // One received frame; qualifiers are {cmd, manual, stop, done}
  task automatic rx(input logic [17:0] g, input logic [23:0] req, input logic [3:0] q);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_group <= g;
    rx_req_group <= req;
    {ctrl_cmd, ctrl_manual, ctrl_stop, motion_done} <= q;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    {ctrl_cmd, ctrl_manual, ctrl_stop, motion_done} <= 4'h0;
  endtask : rx

  // Waits for a diag (st=0) or status (st=1) frame beyond count c
  task automatic wait_frm(input bit st, input int c, input int bound);
    repeat (bound) if ((st ? n_status : n_diag) == c) @(posedge ref_clk);
    check(64'((st ? n_status : n_diag) > c), 64'h1, "frame arrival");
  endtask : wait_frm

  // Gap between two fault repeats, in cycles of the shortened timebase
  task automatic period(input int ms);
    wait_frm(0, n_diag, 1200 * MSD);
    t1 = last_cycle;
    wait_frm(0, n_diag, ms * MSD + 20);
    check(64'((last_cycle - t1) >= (ms - 1) * MSD && (last_cycle - t1) <= ms * MSD + 8),
      64'h1, "fault period");
  endtask : period

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial forever #2.5 ref_clk = ~ref_clk;

  // Whole run is near 43k cycles; 60k means a hang
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    final_report;
  end

  initial
  begin
    repeat (15) @(posedge ref_clk);
    check(64'({tx_valid, tx_kind}), 64'h0, "reset outputs");
    @(posedge ref_clk);
    reset <= 1'b0;
    // Payload layout for each row, answered on request
    foreach (in_tab[i])
    begin
      @(posedge ref_clk);
      {automated, fault_active, dev_enabled, dev_running, warn_lamp, severe_lamp,
        count_valid, ext_valid, bank_valid, bank_select} <= in_tab[i];
      repeat (3) @(posedge ref_clk);
      n0 = n_diag;
      rx(18'h0eaff, 24'h01feca, 4'h0);
      wait_frm(0, n0, 20);
      check(last_data, exp_tab[i], "frame data");
      check(64'({last_group, last_prio}), {43'h0, DIAG_GROUP, DIAG_PRIORITY}, "diag id");
    end
    // Control feedback: automatic start then completion
    n0 = n_status;
    rx(18'h1fedb, 24'h0, 4'h8);
    wait_frm(1, n0, 20);
    check(64'(last_prio), 64'(CONTROL_PRIORITY), "control priority");
    n0 = n_status;
    rx(18'h1fedb, 24'h0, 4'h1);
    wait_frm(1, n0, 20);
    // Manual mode: each repeat answered, silence forces the safe state
    n0 = n_status;
    rx(18'h1fedb, 24'h0, 4'hc);
    wait_frm(1, n0, 20);
    repeat (2 * MSD) @(posedge ref_clk);
    n0 = n_status;
    rx(18'h1fedb, 24'h0, 4'hc);
    wait_frm(1, n0, 20);
    check(64'({manual_active, manual_safe_stop}), 64'h2, "manual running");
    repeat ((MTO + 2) * MSD) @(posedge ref_clk);
    check(64'(manual_safe_stop), 64'h1, "safe stop");
    rx(18'h1fedb, 24'h0, 4'ha);
    repeat (4) @(posedge ref_clk);
    check(64'(manual_active), 64'h0, "manual ended");
    // Foreign group ignored; two requests queued behind a stalled status
    // frame merge into one diag frame
    n0 = n_diag;
    rx(18'h0eaff, 24'h01fecb, 4'h0);
    repeat (20) @(posedge ref_clk);
    check(64'(n_diag - n0), 64'h0, "foreign request");
    slow <= 1'b1;
    rx(18'h1fedb, 24'h0, 4'h8);
    rx(18'h0eaff, 24'h01feca, 4'h0);
    rx(18'h0eaff, 24'h01feca, 4'h0);
    repeat (40) @(posedge ref_clk);
    check(64'(n_diag - n0), 64'h1, "merged requests");
    slow <= 1'b0;
    // Fault repeats: fast for severe, slow otherwise
    fault_active <= 1'b1;
    fault_severe <= 1'b1;
    period(FAST_PERIOD_MS);
    fault_severe <= 1'b0;
    period(SLOW_PERIOD_MS);
    // Clearing a reported fault sends an update in time
    fault_active <= 1'b0;
    n0 = n_diag;
    wait_frm(0, n0, CLEAR_DEADLINE_MS * MSD + 10);
    check(64'(last_data[47:16]), 64'hffffffff, "cleared payload");
    // Idle timer restarted by the device's own status group
    repeat (3000 * MSD) @(posedge ref_clk);
    status_sent <= 1'b1;
    @(posedge ref_clk);
    status_sent <= 1'b0;
    n0 = n_diag;
    repeat (3000 * MSD) @(posedge ref_clk);
    check(64'(n_diag - n0), 64'h0, "idle restart");
    wait_frm(0, n0, 2100 * MSD);
    // Mid-run reset drops the frame offer and the latched safe stop
    check(64'(manual_safe_stop), 64'h1, "safe stop held");
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check(64'({tx_valid, tx_kind, manual_safe_stop}), 64'h0, "mid reset");
    reset <= 1'b0;
    final_report;
  end
endmodule : diag_status_frame_scheduler_tb_top
